// ---- rtl/ffcp_params.svh ----
`ifndef FFCP_PARAMS_SVH
`define FFCP_PARAMS_SVH
// clock and serial timing
`define FFCP_CLK_NS 100
`define FFCP_SCLK_HALF_NS 333
`define FFCP_HALF_CYC ((`FFCP_SCLK_HALF_NS + `FFCP_CLK_NS - 1) / `FFCP_CLK_NS)
`define FFCP_TACH_GATE_MS 1000
`define FFCP_TACH_GATE_CYC (`FFCP_TACH_GATE_MS * 1000000 / `FFCP_CLK_NS)
`define FFCP_RPM_SCALE 16'h001e
// frame lengths, minus one
`define FFCP_ATTEN_LAST 5'h07
`define FFCP_DAC_LAST 5'h0f
// register byte offsets
`define FFCP_REG_ATTEN 8'h00
`define FFCP_REG_DAC 8'h04
`define FFCP_REG_STATUS 8'h08
`define FFCP_REG_READBACK 8'h0c
`define FFCP_REG_THERMO 8'h10
`define FFCP_REG_TACH 8'h14
`define FFCP_REG_RPM 8'h18
// converter channels
`define FFCP_CH_COOLING 3'h0
`define FFCP_CH_BACKEND 3'h4
`define FFCP_CH_HORIZONTAL 3'h5
`define FFCP_CH_VERTICAL 3'h6
`define FFCP_CH_LONGITUDINAL 3'h7
`define FFCP_CODE_MAX 12'hfff
`endif

// ---- rtl/ffcp_pkg.sv ----
`default_nettype none
package ffcp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_LATCH,
        ST_END
    } ffcp_state_type;

    // outgoing pins of the two serial links
    typedef struct packed {
        logic atten_sclk;
        logic atten_sdi;
        logic [3:0] latch;
        logic dac_sclk;
        logic dac_sdi;
        logic dac_cs_n;
    } ffcp_link_type;
endpackage
`default_nettype wire

// ---- rtl/ffcp_host.sv ----
// Local design decisions: the AHB-Lite register port and the register offsets.
`include "ffcp_params.svh"
`timescale 1ns/1ns
`default_nettype none
module ffcp_host #(
    parameter int TACH_GATE_CYC = `FFCP_TACH_GATE_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // attenuator link
    output logic atten_serial_clock,
    output logic atten_serial_in,
    output logic latch_longitudinal,
    output logic latch_vertical,
    output logic latch_horizontal,
    output logic latch_backend,
    input wire logic readback_longitudinal,
    input wire logic readback_vertical,
    input wire logic readback_horizontal,
    input wire logic readback_backend,
    // converter link
    output logic converter_serial_clock,
    output logic converter_serial_in,
    output logic converter_select_n,
    // thermometer, tachometer, revision
    input wire logic thermometer_line_in,
    output logic thermometer_line_out,
    output logic thermometer_line_oe,
    input wire logic rotor_pulse_out,
    input wire logic revision_sense
);
    localparam logic [2:0] HALF_LAST = 3'(`FFCP_HALF_CYC - 1);
    localparam logic [23:0] GATE_LAST = 24'(TACH_GATE_CYC - 1);

    // input synchronisers: readbacks 0..3, thermo 4, tach 5, revision 6
    logic [6:0] sync1_r, sync2_r;
    logic tach_prev_r;
    wire logic [6:0] pins = {revision_sense, rotor_pulse_out,
        thermometer_line_in, readback_backend, readback_horizontal,
        readback_vertical, readback_longitudinal};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // idle pin levels: no false tach edge, no start before sensing
            sync1_r <= 7'h70;
            sync2_r <= 7'h70;
            tach_prev_r <= 1'b1;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            tach_prev_r <= sync2_r[5];
        end
    end
    wire logic modern = !sync2_r[6];

    function automatic logic [31:0] read_mux(input logic [7:0] a,
        input logic [31:0] atten, input logic [31:0] dac,
        input logic [31:0] stat, input logic [31:0] rb,
        input logic [31:0] th, input logic [31:0] ta,
        input logic [31:0] rpm);
        if (a == `FFCP_REG_ATTEN) read_mux = atten;
        else if (a == `FFCP_REG_DAC) read_mux = dac;
        else if (a == `FFCP_REG_STATUS) read_mux = stat;
        else if (a == `FFCP_REG_READBACK) read_mux = rb;
        else if (a == `FFCP_REG_THERMO) read_mux = th;
        else if (a == `FFCP_REG_TACH) read_mux = ta;
        else if (a == `FFCP_REG_RPM) read_mux = rpm;
        else read_mux = 32'h0000_0000;
    endfunction

    // bus and register state
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] waddr_r, waddr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic [9:0] atten_cfg_r, atten_cfg_nxt;
    logic [14:0] dac_cfg_r, dac_cfg_nxt;
    logic therm_drive_r, therm_drive_nxt;
    // serial engine state
    ffcp_pkg::ffcp_state_type state_r, state_nxt;
    ffcp_pkg::ffcp_link_type link_r, link_nxt;
    logic [2:0] div_r, div_nxt;
    logic [4:0] bit_r, bit_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic is_dac_r, is_dac_nxt;
    logic [31:0] rb_r, rb_nxt;
    // tachometer state
    logic [23:0] gate_r, gate_nxt;
    logic [15:0] edges_r, edges_nxt, tach_r, tach_nxt;
    logic [31:0] rpm_r, rpm_nxt;

    wire logic addr_ok = hsel && htrans[1] && hready;
    wire logic busy = state_r != ffcp_pkg::ST_IDLE;
    wire logic tick = div_r == HALF_LAST;
    wire logic gate_end = gate_r == GATE_LAST;
    wire logic [31:0] status = {30'h0, modern, busy};

    always_comb begin
        wr_pend_nxt = addr_ok && hwrite;
        waddr_nxt = addr_ok ? haddr[7:0] : waddr_r;
        hrdata_nxt = hrdata_r;
        if (addr_ok && !hwrite)
            hrdata_nxt = read_mux(haddr[7:0], {22'h0, atten_cfg_r},
                {17'h0, dac_cfg_r}, status, rb_r,
                {30'h0, sync2_r[4], therm_drive_r}, {16'h0, tach_r}, rpm_r);
        atten_cfg_nxt = atten_cfg_r;
        dac_cfg_nxt = dac_cfg_r;
        therm_drive_nxt = therm_drive_r;
        state_nxt = state_r;
        link_nxt = link_r;
        div_nxt = (busy && !tick) ? div_r + 3'h1 : 3'h0;
        bit_nxt = bit_r;
        shift_nxt = shift_r;
        is_dac_nxt = is_dac_r;
        rb_nxt = rb_r;
        if (wr_pend_r && waddr_r == `FFCP_REG_THERMO)
            therm_drive_nxt = hwdata[0];
        case (state_r)
            ffcp_pkg::ST_IDLE: begin
                // attenuator and converter writes while busy or on an older unit are dropped
                if (wr_pend_r && modern && waddr_r == `FFCP_REG_ATTEN) begin
                    atten_cfg_nxt = hwdata[9:0];
                    shift_nxt = {hwdata[7:0], 8'h00};
                    bit_nxt = `FFCP_ATTEN_LAST;
                    is_dac_nxt = 1'b0;
                    link_nxt.atten_sdi = hwdata[7];
                    state_nxt = ffcp_pkg::ST_LOW;
                end else if (wr_pend_r && modern
                        && waddr_r == `FFCP_REG_DAC) begin
                    // frame: zero, channel, 12-bit code
                    dac_cfg_nxt = hwdata[14:0];
                    shift_nxt = {1'b0, hwdata[14:0]};
                    bit_nxt = `FFCP_DAC_LAST;
                    is_dac_nxt = 1'b1;
                    link_nxt.dac_sdi = 1'b0;
                    link_nxt.dac_cs_n = 1'b0;
                    state_nxt = ffcp_pkg::ST_LOW;
                end
            end
            ffcp_pkg::ST_LOW: if (tick) begin
                if (is_dac_r) link_nxt.dac_sclk = 1'b1;
                else begin
                    link_nxt.atten_sclk = 1'b1;
                    for (int i = 0; i < 4; i++)
                        rb_nxt[i*8 +: 8] = {rb_r[i*8 +: 7], sync2_r[i]};
                end
                state_nxt = ffcp_pkg::ST_HIGH;
            end
            ffcp_pkg::ST_HIGH: if (tick) begin
                link_nxt.atten_sclk = 1'b0;
                link_nxt.dac_sclk = 1'b0;
                if (bit_r == 5'h00) begin
                    if (is_dac_r) state_nxt = ffcp_pkg::ST_END;
                    else begin
                        link_nxt.latch[atten_cfg_r[9:8]] = 1'b1;
                        state_nxt = ffcp_pkg::ST_LATCH;
                    end
                end else begin
                    bit_nxt = bit_r - 5'h01;
                    shift_nxt = {shift_r[14:0], 1'b0};
                    if (is_dac_r) link_nxt.dac_sdi = shift_r[14];
                    else link_nxt.atten_sdi = shift_r[14];
                    state_nxt = ffcp_pkg::ST_LOW;
                end
            end
            ffcp_pkg::ST_LATCH: if (tick) begin
                link_nxt.latch = 4'h0;
                state_nxt = ffcp_pkg::ST_END;
            end
            ffcp_pkg::ST_END: if (tick) begin
                link_nxt.dac_cs_n = 1'b1;
                state_nxt = ffcp_pkg::ST_IDLE;
            end
            default: state_nxt = ffcp_pkg::ST_IDLE;
        endcase
        // speed: full periods per gate times scale
        gate_nxt = gate_end ? 24'h000000 : gate_r + 24'h000001;
        edges_nxt = edges_r;
        tach_nxt = tach_r;
        rpm_nxt = rpm_r;
        if (sync2_r[5] && !tach_prev_r) edges_nxt = edges_r + 16'h0001;
        if (gate_end) begin
            tach_nxt = edges_nxt;
            rpm_nxt = 32'(edges_nxt) * 32'(`FFCP_RPM_SCALE);
            edges_nxt = 16'h0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            waddr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            atten_cfg_r <= 10'h000;
            dac_cfg_r <= 15'h0000;
            therm_drive_r <= 1'b0;
            state_r <= ffcp_pkg::ST_IDLE;
            link_r <= '{dac_cs_n: 1'b1, default: '0};
            div_r <= 3'h0;
            bit_r <= 5'h00;
            shift_r <= 16'h0000;
            is_dac_r <= 1'b0;
            rb_r <= 32'h0000_0000;
            gate_r <= 24'h000000;
            edges_r <= 16'h0000;
            tach_r <= 16'h0000;
            rpm_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            waddr_r <= waddr_nxt;
            hrdata_r <= hrdata_nxt;
            atten_cfg_r <= atten_cfg_nxt;
            dac_cfg_r <= dac_cfg_nxt;
            therm_drive_r <= therm_drive_nxt;
            state_r <= state_nxt;
            link_r <= link_nxt;
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            shift_r <= shift_nxt;
            is_dac_r <= is_dac_nxt;
            rb_r <= rb_nxt;
            gate_r <= gate_nxt;
            edges_r <= edges_nxt;
            tach_r <= tach_nxt;
            rpm_r <= rpm_nxt;
        end
    end

    // constant-valued flops keep every output registered
    logic ready_r, zero_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_r <= 1'b0;
            zero_r <= 1'b0;
        end else begin
            ready_r <= 1'b1;
            zero_r <= 1'b0;
        end
    end

    assign hreadyout = ready_r;
    assign hresp = zero_r;
    assign hrdata = hrdata_r;
    assign atten_serial_clock = link_r.atten_sclk;
    assign atten_serial_in = link_r.atten_sdi;
    assign latch_longitudinal = link_r.latch[0];
    assign latch_vertical = link_r.latch[1];
    assign latch_horizontal = link_r.latch[2];
    assign latch_backend = link_r.latch[3];
    assign converter_serial_clock = link_r.dac_sclk;
    assign converter_serial_in = link_r.dac_sdi;
    assign converter_select_n = link_r.dac_cs_n;
    assign thermometer_line_out = zero_r;
    assign thermometer_line_oe = therm_drive_r;

    // checks
    logic [3:0] rise_cnt_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) rise_cnt_r <= 4'h0;
        else if (state_r == ffcp_pkg::ST_IDLE) rise_cnt_r <= 4'h0;
        else if (link_r.atten_sclk && !link_nxt.atten_sclk)
            rise_cnt_r <= rise_cnt_r;
        else if (!link_r.atten_sclk && link_nxt.atten_sclk)
            rise_cnt_r <= rise_cnt_r + 4'h1;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence high_phase;
        link_r.atten_sclk [*4] ##1 !link_r.atten_sclk;
    endsequence
    sequence latch_phase;
        (|link_r.latch) [*4] ##1 (link_r.latch == 4'h0);
    endsequence
    sclk_half_period_a: assert property (
        $rose(link_r.atten_sclk) |-> high_phase)
        else $error("attenuator clock high phase not four cycles");
    one_latch_a: assert property ($onehot0(link_r.latch))
        else $error("more than one latch enable high");
    latch_after_word_a: assert property (
        $rose(|link_r.latch) |-> rise_cnt_r == 4'h8
        && !link_r.atten_sclk ##0 latch_phase)
        else $error("latch raised before the word was shifted");
    word_length_a: assert property (
        link_r.atten_sclk |-> rise_cnt_r <= 4'h8 && !is_dac_r)
        else $error("attenuator word longer than eight bits");
    frame_select_a: assert property (
        link_r.dac_sclk |-> !link_r.dac_cs_n)
        else $error("converter clocked outside its frame");
    frame_release_a: assert property (
        $rose(link_r.dac_cs_n) |-> $past(state_r) == ffcp_pkg::ST_END
        && !link_r.dac_sclk)
        else $error("converter frame ended early");
    old_unit_a: assert property (
        state_r == ffcp_pkg::ST_IDLE && !modern |=>
        state_r == ffcp_pkg::ST_IDLE)
        else $error("transfer started on an older interface");
    rpm_scale_a: assert property (
        gate_end |=> rpm_r == 32'(tach_r) * 32'(`FFCP_RPM_SCALE))
        else $error("speed not frequency times thirty");
endmodule // ffcp_host
`default_nettype wire

// ---- verif/ffcp_device.sv ----
`timescale 1ns/1ns
`default_nettype none
module ffcp_device #(
    parameter int TACH_HALF_NS = 10000
) (
    // attenuator link
    input wire logic atten_clk,
    input wire logic atten_sdi,
    input wire logic [3:0] latch,
    output logic [3:0] readback,
    // converter link
    input wire logic dac_clk,
    input wire logic dac_sdi,
    input wire logic dac_cs_n,
    // thermometer and tachometer
    input wire logic therm_pull,
    output logic therm_level,
    output logic tach
);
    logic [7:0] shift_r = 8'h00;
    logic [7:0] setting [4];
    logic [11:0] code [8];
    logic [15:0] dac_shift = 16'h0000;
    int atten_bits = 0;
    int last_bits = 0;
    int dac_bits = 0;
    int frame_bits = 0;
    initial begin
        foreach (setting[i]) setting[i] = 8'h00;
        foreach (code[i]) code[i] = 12'h000;
        tach = 1'b1;
    end
    always @(posedge atten_clk) begin
        shift_r = {shift_r[6:0], atten_sdi};
        atten_bits = atten_bits + 1;
    end
    assign readback = {4{shift_r[7]}};
    for (genvar i = 0; i < 4; i++) begin : g_latch
        always @(posedge latch[i]) begin
            setting[i] = shift_r;
            last_bits = atten_bits;
            atten_bits = 0;
        end
    end
    always @(negedge dac_cs_n) dac_bits = 0;
    always @(posedge dac_clk) begin
        if (!dac_cs_n) begin
            dac_shift = {dac_shift[14:0], dac_sdi};
            dac_bits = dac_bits + 1;
        end
    end
    always @(posedge dac_cs_n) begin
        frame_bits = dac_bits;
        code[dac_shift[14:12]] = dac_shift[11:0];
    end
    // fan drive falls as the code rises
    wire [12:0] fan_drive = 13'h1000 - {1'b0, code[0]};
    // open-collector thermometer line with pull-up; tach is a driven square wave
    assign therm_level = therm_pull ? 1'b0 : 1'b1;
    always #(TACH_HALF_NS) tach = ~tach;
endmodule // ffcp_device
`default_nettype wire

// ---- verif/testbench.sv ----
`include "ffcp_params.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic hclk, hresetn, hsel, hwrite, rev;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, sclk, sdi, dclk, dsdi, dcs_n, t_out, t_oe, t_lvl;
    logic tach;
    logic [3:0] le, rb;
    logic [15:0] seed;
    logic [7:0] w, prev;
    logic [11:0] c;
    logic [2:0] chans [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    int bad_count = 0;
    int n_checks = 0;
    ffcp_host #(.TACH_GATE_CYC(2000)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .atten_serial_clock(sclk), .atten_serial_in(sdi),
        .latch_longitudinal(le[0]), .latch_vertical(le[1]),
        .latch_horizontal(le[2]), .latch_backend(le[3]),
        .readback_longitudinal(rb[0]), .readback_vertical(rb[1]),
        .readback_horizontal(rb[2]), .readback_backend(rb[3]),
        .converter_serial_clock(dclk), .converter_serial_in(dsdi),
        .converter_select_n(dcs_n), .thermometer_line_in(t_lvl),
        .thermometer_line_out(t_out), .thermometer_line_oe(t_oe),
        .rotor_pulse_out(tach), .revision_sense(rev));
    ffcp_device u_dev (.atten_clk(sclk), .atten_sdi(sdi), .latch(le),
        .readback(rb), .dac_clk(dclk), .dac_sdi(dsdi), .dac_cs_n(dcs_n),
        .therm_pull(t_oe && !t_out), .therm_level(t_lvl), .tach(tach));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic final_report();
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        s = 32'h1;
        while (s[0] !== 1'b0) bus(1'b0, `FFCP_REG_STATUS, 32'h0, s);
    endtask
    initial begin
        repeat (30000) @(posedge hclk);
        bad_count++;
        final_report();
    end
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        rev = 1'b1;
        seed = 16'h0025;
        prev = 8'h00;
        repeat (6) @(posedge hclk);
        check({dcs_n, le, hresp}, 6'h20);
        hresetn <= 1'b1;
        repeat (5) @(posedge hclk);
        // floating revision sense: starts are refused
        bus(1'b0, `FFCP_REG_STATUS, 32'h0, rd);
        check(rd[1], 1'b0);
        bus(1'b1, `FFCP_REG_ATTEN, 32'h5a, rd);
        repeat (90) @(posedge hclk);
        check(u_dev.setting[0], 8'h00);
        rev <= 1'b0;
        repeat (5) @(posedge hclk);
        bus(1'b0, `FFCP_REG_STATUS, 32'h0, rd);
        check(rd, 32'h2);
        for (int t = 0; t < 4; t++) begin
            seed = lfsr(seed);
            w = (t == 3) ? 8'hff : seed[7:0];
            wait_idle();
            bus(1'b1, `FFCP_REG_ATTEN, {22'h0, t[1:0], w}, rd);
            // second write while busy must be dropped
            bus(1'b1, `FFCP_REG_ATTEN, {22'h0, t[1:0], ~w}, rd);
            wait_idle();
            check(u_dev.setting[t], w);
            check(u_dev.last_bits, 8);
            bus(1'b0, `FFCP_REG_READBACK, 32'h0, rd);
            check(rd, {4{prev}});
            prev = w;
        end
        check(u_dev.code[5], 12'h000);
        for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            c = (k == 1) ? 12'hfff : seed[11:0];
            wait_idle();
            bus(1'b1, `FFCP_REG_DAC, {17'h0, chans[k], c}, rd);
            wait_idle();
            check(u_dev.code[chans[k]], c);
            check(u_dev.frame_bits, 16);
            if (k == 0) check(u_dev.fan_drive, 13'h1000 - {1'b0, c});
        end
        for (int v = 1; v >= 0; v--) begin
            bus(1'b1, `FFCP_REG_THERMO, v, rd);
            repeat (4) @(posedge hclk);
            bus(1'b0, `FFCP_REG_THERMO, 32'h0, rd);
            check(rd[1], !v[0]);
        end
        repeat (4100) @(posedge hclk);
        bus(1'b0, `FFCP_REG_TACH, 32'h0, rd);
        check(rd >= 9 && rd <= 11, 1'b1);
        w = rd[7:0];
        bus(1'b0, `FFCP_REG_RPM, 32'h0, rd);
        check(rd, w * 30);
        bus(1'b1, 8'h40, 32'hffff, rd);
        bus(1'b0, 8'h40, 32'h0, rd);
        check(rd, 32'h0);
        final_report();
    end
endmodule // testbench
`default_nettype wire
